//--- core/tpm_top.sv
// Purpose: Pattern generator after converter, then horizontal mirror
// Assumes: Converter markers one-cycle with pixel valid
// Notes:   Pattern select sampled at frame start, mirror select at each line end
`timescale 1ns/1ns
`include "tpm_regs.svh"
module tpm_top
    import tpm_pkg::*;
#(
    parameter int PIX_W = 8,
    parameter int MAX_W = 2048
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Settings
    input  wire logic [2:0]       pattern_select,
    input  wire logic             mirror_select,
    // Converter stream
    input  wire logic             adc_valid,
    input  wire logic             adc_sof,
    input  wire logic             adc_sol,
    input  wire logic             adc_eol,
    input  wire logic [PIX_W-1:0] adc_pix,
    // Downstream stream
    output logic                  out_valid,
    output logic                  out_sof,
    output logic                  out_sol,
    output logic                  out_eol,
    output logic [PIX_W-1:0]      out_pix
);
    tpm_mirror_if #(.PIX_W(PIX_W)) st_if ();

    // Qualified converter markers
    logic             in_sof;
    logic             in_sol;
    logic             in_eol;
    // Settings and position state
    logic [2:0]       pat_q;
    logic [2:0]       pat_now;
    logic [PIX_W-1:0] col_q;
    logic [PIX_W-1:0] col_now;
    logic [PIX_W-1:0] row_q;
    logic [PIX_W-1:0] row_now;
    logic [PIX_W-1:0] frm_q;
    logic [PIX_W-1:0] frm_now;
    logic             frm_seen_q;
    // Pattern values
    logic [PIX_W-1:0] horiz_pix;
    logic [PIX_W-1:0] vert_pix;
    logic [PIX_W-1:0] diag_pix;
    logic [PIX_W-1:0] pur_pix;
    logic [PIX_W-1:0] gen_pix;
    // Stage toward mirror
    logic             v_q;
    logic             sof_q;
    logic             sol_q;
    logic             eol_q;
    logic [PIX_W-1:0] pix_q;

    // Markers count only beside a valid pixel
    assign in_sof = adc_valid && adc_sof;
    assign in_sol = adc_valid && adc_sol;
    assign in_eol = adc_valid && adc_eol;

    // Position of the pixel now on the converter bus
    assign pat_now = in_sof ? pattern_select : pat_q;
    assign col_now = in_sol ? '0 : col_q;
    assign row_now = in_sof ? '0 : (in_sol ? row_q + PIX_W'(1) : row_q);
    assign frm_now = (in_sof && frm_seen_q) ? frm_q + PIX_W'(1) : frm_q;

    // Pattern select held for the frame
    always_ff @(posedge clk) begin
        if (rst) begin
            pat_q <= `TPM_PAT_OFF;
        end else if (in_sof) begin
            pat_q <= pattern_select;
        end
    end

    // Column counter
    always_ff @(posedge clk) begin
        if (rst) begin
            col_q <= '0;
        end else if (adc_valid) begin
            col_q <= col_now + PIX_W'(1);
        end
    end

    // Row counter
    always_ff @(posedge clk) begin
        if (rst) begin
            row_q <= '0;
        end else if (adc_valid) begin
            row_q <= row_now;
        end
    end

    // Frame counter, zero for first frame after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            frm_q <= '0;
        end else begin
            frm_q <= frm_now;
        end
    end

    // First frame seen since reset
    always_ff @(posedge clk) begin
        if (rst) begin
            frm_seen_q <= 1'h0;
        end else if (in_sof) begin
            frm_seen_q <= 1'h1;
        end
    end

    // Pattern values
    assign horiz_pix = col_now;
    assign vert_pix  = row_now;
    assign diag_pix  = col_now + row_now + frm_now;
    assign pur_pix   = frm_now;

    // Pattern choice
    always_comb begin
        case (pat_now)
            `TPM_PAT_OFF:    gen_pix = adc_pix;
            `TPM_PAT_HORIZ:  gen_pix = horiz_pix;
            `TPM_PAT_VERT:   gen_pix = vert_pix;
            `TPM_PAT_DIAG:   gen_pix = diag_pix;
            `TPM_PAT_PURITY: gen_pix = pur_pix;
            default:         gen_pix = adc_pix;
        endcase
    end

    // Stage valid
    always_ff @(posedge clk) begin
        if (rst) begin
            v_q <= 1'h0;
        end else begin
            v_q <= adc_valid;
        end
    end

    // Stage frame marker
    always_ff @(posedge clk) begin
        if (rst) begin
            sof_q <= 1'h0;
        end else begin
            sof_q <= in_sof;
        end
    end

    // Stage line start marker
    always_ff @(posedge clk) begin
        if (rst) begin
            sol_q <= 1'h0;
        end else begin
            sol_q <= in_sol;
        end
    end

    // Stage line end marker
    always_ff @(posedge clk) begin
        if (rst) begin
            eol_q <= 1'h0;
        end else begin
            eol_q <= in_eol;
        end
    end

    // Stage pixel, pattern replaces converter data
    always_ff @(posedge clk) begin
        if (rst) begin
            pix_q <= '0;
        end else if (adc_valid) begin
            pix_q <= gen_pix;
        end
    end

    assign st_if.valid = v_q;
    assign st_if.sof   = sof_q;
    assign st_if.sol   = sol_q;
    assign st_if.eol   = eol_q;
    assign st_if.pix   = pix_q;

    tpm_mirror #(.PIX_W(PIX_W), .MAX_W(MAX_W)) u_mirror (
        .clk           (clk),
        .rst           (rst),
        .mirror_select (mirror_select),
        .in_s          (st_if.dst),
        .out_valid     (out_valid),
        .out_sol       (out_sol),
        .out_eol       (out_eol),
        .out_sof       (out_sof),
        .out_pix       (out_pix)
    );
endmodule

//--- core/tpm_regs.svh
// Purpose: Constants for the test pattern and mirror stage
// Assumes: Included by bare name
// Notes:   Codes for pattern_select and mirror_select
// Contract
// - Pattern codes: off, horiz, vert, diagonal, purity
// - Horizontal ramp steps one per pixel, wraps
// - Horizontal ramp restarts at zero each line
// - Vertical ramp steps one per line, wraps
// - Diagonal start advances one per frame
// - Purity: all pixels of frame equal
// - Purity value steps one per frame, wraps
// - Pattern replaces converter pixels before later stages
// - Mirror reverses pixel order within each line at full rate
// - Mirror codes: zero normal, one reversed
`ifndef TPM_REGS_SVH
`define TPM_REGS_SVH
`define TPM_PAT_OFF    3'h0
`define TPM_PAT_HORIZ  3'h1
`define TPM_PAT_VERT   3'h2
`define TPM_PAT_DIAG   3'h3
`define TPM_PAT_PURITY 3'h4
`define TPM_MIR_NORMAL 1'h0
`define TPM_MIR_FLIP   1'h1
`endif

//--- core/tpm_pkg.sv
// Purpose: Types for the test pattern and mirror stage
// Assumes: Nothing
// Notes:   Mirror line buffer bank state
package tpm_pkg;
    typedef enum logic [1:0] {
        TPM_BANK_IDLE = 2'h1,
        TPM_BANK_READ = 2'h2
    } tpm_bank_t;
endpackage

//--- core/tpm_mirror_if.sv
// Purpose: Pixel stream carrier between pattern stage and mirror
// Assumes: One pixel per valid cycle
// Notes:   Frame and line markers travel with the pixel
`timescale 1ns/1ns
interface tpm_mirror_if #(parameter int PIX_W = 8);
    logic             valid;
    logic             sol;
    logic             eol;
    logic             sof;
    logic [PIX_W-1:0] pix;
    modport src (output valid, output sol, output eol, output sof, output pix);
    modport dst (input  valid, input  sol, input  eol, input  sof, input  pix);
endinterface

//--- core/tpm_mirror.sv
// Purpose: Horizontal mirror with two ping-pong line buffers
// Assumes: Lines no longer than MAX_W, gap between lines at least one cycle
// Notes:   Output lags one line; full pixel rate kept
`timescale 1ns/1ns
`include "tpm_regs.svh"
module tpm_mirror
    import tpm_pkg::*;
#(
    parameter int PIX_W = 8,
    parameter int MAX_W = 2048,
    parameter int AW    = $clog2(MAX_W)
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control
    input  wire logic             mirror_select,
    // Input stream
    tpm_mirror_if.dst             in_s,
    // Output stream
    output logic                  out_valid,
    output logic                  out_sol,
    output logic                  out_eol,
    output logic                  out_sof,
    output logic [PIX_W-1:0]      out_pix
);
    logic [PIX_W-1:0] mem_q [0:1][0:MAX_W-1];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    len_q;
    logic [AW-1:0]    rd_q;
    logic             wbank_q;
    logic             mode_q;
    logic             sof_line_q;
    logic             sof_pend_q;
    tpm_bank_t        st_q;

    // Write side
    always_ff @(posedge clk) begin
        if (in_s.valid) begin
            mem_q[wbank_q][wr_q] <= in_s.pix;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q       <= '0;
            wbank_q    <= 1'h0;
            len_q      <= '0;
            sof_line_q <= 1'h0;
            mode_q     <= `TPM_MIR_NORMAL;
        end else if (in_s.valid) begin
            if (in_s.sol) begin
                sof_line_q <= in_s.sof;
            end
            if (in_s.eol) begin
                wr_q    <= '0;
                wbank_q <= ~wbank_q;
                len_q   <= in_s.sol ? '0 : wr_q;
                mode_q  <= mirror_select;
            end else begin
                wr_q <= in_s.sol ? AW'(1) : wr_q + AW'(1);
            end
        end
    end

    // Read side: replay finished line forward or reversed
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q       <= TPM_BANK_IDLE;
            rd_q       <= '0;
            sof_pend_q <= 1'h0;
            out_valid  <= 1'h0;
            out_sol    <= 1'h0;
            out_eol    <= 1'h0;
            out_sof    <= 1'h0;
            out_pix    <= '0;
        end else begin
            out_valid <= 1'h0;
            out_sol   <= 1'h0;
            out_eol   <= 1'h0;
            out_sof   <= 1'h0;
            case (st_q)
                TPM_BANK_IDLE: begin
                    if (in_s.valid && in_s.eol) begin
                        st_q       <= TPM_BANK_READ;
                        rd_q       <= '0;
                        sof_pend_q <= in_s.sol ? in_s.sof : sof_line_q;
                    end
                end
                TPM_BANK_READ: begin
                    out_valid <= 1'h1;
                    out_sol   <= (rd_q == '0);
                    out_sof   <= (rd_q == '0) && sof_pend_q;
                    out_eol   <= (rd_q == len_q);
                    out_pix   <= (mode_q == `TPM_MIR_FLIP) ? mem_q[~wbank_q][len_q - rd_q]
                                                           : mem_q[~wbank_q][rd_q];
                    rd_q      <= rd_q + AW'(1);
                    if (rd_q == len_q) begin
                        st_q <= TPM_BANK_IDLE;
                    end
                end
                default: st_q <= TPM_BANK_IDLE;
            endcase
        end
    end
endmodule

//--- verif/tpm_chk.sv
// Purpose: Port checks for the pattern and mirror stage
// Assumes: Settings held steady through each frame
// Notes:   Bound to tpm_top
`timescale 1ns/1ns
`include "tpm_regs.svh"
module tpm_chk #(
    parameter int PIX_W = 8
) (
    // Clock, reset, settings
    input wire logic             clk,
    input wire logic             rst,
    input wire logic [2:0]       pattern_select,
    input wire logic             mirror_select,
    // Streams
    input wire logic             adc_valid,
    input wire logic             adc_eol,
    input wire logic             out_valid,
    input wire logic             out_sol,
    input wire logic             out_eol,
    input wire logic [PIX_W-1:0] out_pix
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic hz;
    logic nx;
    assign hz = pattern_select == `TPM_PAT_HORIZ;
    assign nx = out_valid && !out_eol;
    sequence s_eol; adc_valid && adc_eol; endsequence
    sequence s_rep; out_valid && out_sol; endsequence
    property p_lat; s_eol |-> ##3 s_rep; endproperty
    a_lat: assert property (p_lat) else $error("late replay");
    property p_rate; nx |=> out_valid; endproperty
    a_rate: assert property (p_rate) else $error("gap in line");
    property p_hup; hz && !mirror_select && nx |=> out_pix == PIX_W'($past(out_pix) + 1); endproperty
    a_hup: assert property (p_hup) else $error("ramp step");
    property p_hsol; hz && !mirror_select && out_sol |-> out_pix == '0; endproperty
    a_hsol: assert property (p_hsol) else $error("ramp start");
    property p_hdn; hz && mirror_select && nx |=> out_pix == PIX_W'($past(out_pix) - 1); endproperty
    a_hdn: assert property (p_hdn) else $error("mirror step");
    property p_heol; hz && mirror_select && out_eol |-> out_pix == '0; endproperty
    a_heol: assert property (p_heol) else $error("mirror end");
    property p_vert; pattern_select == `TPM_PAT_VERT && nx |=> out_pix == $past(out_pix); endproperty
    a_vert: assert property (p_vert) else $error("line not flat");
    property p_pur; pattern_select == `TPM_PAT_PURITY && nx |=> out_pix == $past(out_pix); endproperty
    a_pur: assert property (p_pur) else $error("purity differs");
endmodule
bind tpm_top tpm_chk #(.PIX_W(PIX_W)) chk (.clk(clk), .rst(rst), .pattern_select(pattern_select),
    .mirror_select(mirror_select), .adc_valid(adc_valid), .adc_eol(adc_eol), .out_valid(out_valid),
    .out_sol(out_sol), .out_eol(out_eol), .out_pix(out_pix));

//--- verif/tpm_adc_src.sv
// Purpose: Converter stream model
// Assumes: Frame starts on rising start
// Notes:   Pixel value 3*col+row, inverted when idle
`timescale 1ns/1ns
module tpm_adc_src #(
    parameter int PIX_W = 8,
    parameter int W     = 10,
    parameter int H     = 3,
    parameter int G     = 14
) (
    // Clock and request
    input wire logic         clk,
    input wire logic         start,
    // Converter stream
    output logic             adc_valid,
    output logic             adc_sof,
    output logic             adc_sol,
    output logic             adc_eol,
    output logic [PIX_W-1:0] adc_pix
);
    initial begin
        {adc_valid, adc_sof, adc_sol, adc_eol} = 4'h0;
        adc_pix = '0;
    end
    always @(posedge start) begin
        for (int r = 0; r < H; r++) begin
            for (int c = 0; c < W; c++) begin
                @(posedge clk);
                #1;
                {adc_valid, adc_sof, adc_sol, adc_eol} = {1'h1, r == 0 && c == 0, c == 0, c == W - 1};
                adc_pix = PIX_W'(3 * c + r);
            end
            @(posedge clk);
            #1;
            {adc_valid, adc_sof, adc_sol, adc_eol} = 4'h0;
            adc_pix = ~adc_pix;
            repeat (G) @(posedge clk);
        end
    end
endmodule

//--- verif/test_pattern_and_mirror_bench.sv
// Purpose: Self-checking bench for the pattern and mirror stage
// Assumes: Three-bit pixels so ramps wrap fast
// Notes:   Frame count tracked from reset
`timescale 1ns/1ns
`include "tpm_regs.svh"
module test_pattern_and_mirror_bench;
    localparam int PW = 3;
    localparam int W  = 10;
    localparam int H  = 3;
    logic          clk, rst, start, mir, av, asof, asol, aeol, ov, osof, osol, oeol;
    logic [2:0]    pat;
    logic [PW-1:0] apix, opix;
    logic [PW-1:0] q[$];
    logic [2:0]    f[$];
    int            err_total, compares, fcnt;
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    tpm_top #(.PIX_W(PW), .MAX_W(16)) dut (.clk(clk), .rst(rst), .pattern_select(pat), .mirror_select(mir),
        .adc_valid(av), .adc_sof(asof), .adc_sol(asol), .adc_eol(aeol), .adc_pix(apix), .out_valid(ov),
        .out_sof(osof), .out_sol(osol), .out_eol(oeol), .out_pix(opix));
    tpm_adc_src #(.PIX_W(PW), .W(W), .H(H)) src (.clk(clk), .start(start), .adc_valid(av), .adc_sof(asof),
        .adc_sol(asol), .adc_eol(aeol), .adc_pix(apix));
    always @(posedge clk) begin
        if (ov) begin
            q.push_back(opix);
            f.push_back({osof, osol, oeol});
        end
    end
    task check(input logic [PW-1:0] seen, input logic [PW-1:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task frame(input logic [2:0] p, input logic m);
        int n;
        @(posedge clk);
        #1 pat = p;
        mir = m;
        q.delete();
        f.delete();
        start = 1'h1;
        @(posedge clk);
        #1 start = 1'h0;
        n = 0;
        while (q.size() < W * H && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n == 2000) begin
            err_total++;
            test_done;
        end
        repeat (4) @(posedge clk);
        for (int i = 0; i < W * H; i++) check(f[i], {i == 0, i % W == 0, i % W == W - 1});
        fcnt++;
    endtask
    task t_off;
        frame(`TPM_PAT_OFF, `TPM_MIR_NORMAL);
        for (int i = 0; i < W * H; i++) check(q[i], PW'(3 * (i % W) + i / W));
        frame(`TPM_PAT_OFF, `TPM_MIR_FLIP);
        for (int i = 0; i < W * H; i++) check(q[i], PW'(3 * (W - 1 - i % W) + i / W));
        frame(3'h7, `TPM_MIR_NORMAL);
        for (int i = 0; i < W * H; i++) check(q[i], PW'(3 * (i % W) + i / W));
    endtask
    task t_ramps;
        frame(`TPM_PAT_HORIZ, `TPM_MIR_NORMAL);
        for (int i = 0; i < W * H; i++) check(q[i], PW'(i % W));
        frame(`TPM_PAT_HORIZ, `TPM_MIR_FLIP);
        for (int i = 0; i < W * H; i++) check(q[i], PW'(W - 1 - i % W));
        frame(`TPM_PAT_VERT, `TPM_MIR_NORMAL);
        for (int i = 0; i < W * H; i++) check(q[i], PW'(i / W));
    endtask
    task t_diag;
        for (int k = 0; k < 2; k++) begin
            frame(`TPM_PAT_DIAG, k[0]);
            for (int i = 0; i < W * H; i++) check(q[i], PW'((k ? W - 1 - i % W : i % W) + i / W + fcnt - 1));
        end
    endtask
    task t_purity;
        for (int k = 0; k < 9; k++) begin
            frame(`TPM_PAT_PURITY, `TPM_MIR_NORMAL);
            for (int i = 0; i < W * H; i++) check(q[i], PW'(fcnt - 1));
        end
    endtask
    task t_reset;
        @(posedge clk);
        #1 rst = 1'h1;
        repeat (12) @(posedge clk);
        #1 rst = 1'h0;
        fcnt = 0;
        frame(`TPM_PAT_PURITY, `TPM_MIR_NORMAL);
        for (int i = 0; i < W * H; i++) check(q[i], PW'(0));
    endtask
    initial begin
        {rst, start, mir, pat} = 6'h20;
        err_total = 0;
        compares = 0;
        fcnt = 0;
        repeat (12) @(posedge clk);
        #1 rst = 1'h0;
        t_off;
        t_ramps;
        t_diag;
        t_purity;
        t_reset;
        test_done;
    end
endmodule
